/* tsc_pkg.sv */
// constants and types for the trigger timestamp capture block
// Notes on behaviour
// - a wide counter advances once per sample clock in use
// - counter clears on software reset command or on card start by mode
// - each trigger copies the present count into the timestamp fifo
// - stored value equals samples counted since last counter clear
// - mode 0 disables stamping, mode 2h is free running standard mode
// - command 1h clears counters and latches host time and date
// - mode 4h clears the counter at every card start
// - source 100h counts whole width on the sample clock
// - source 200h splits counter, high part on reference rising edges
// - source 400h splits counter, high part on reference falling edges
// - code 2000h puts two 10-bit incremental counts in top 20 bits
// - code 1000h puts auxiliary inputs in the top byte
// - without auxiliary or incremental capture upper bits are zero
// - without extra feature exactly one stamp per trigger
// - feature 10000h adds one stamp for first A area sample
// - clear takes effect only when card clock generation runs
// - writable millisecond timeout bounds wait for reference edge
// - read-only bitmap reports supported mode codes
// - reset time holds hours 23:16, minutes 15:8, seconds 7:0
// - reset date holds year 31:16, month 15:8, day 7:0
// - standard mode counter runs regardless of acquisition start and stop
// - split mode: reference edge clears low part, bumps high part
package tsc_pkg;
   // register indices; byte address is four times the index
   localparam logic [15:0] IDX_CMD     = 16'hb798;
   localparam logic [15:0] IDX_CAPS    = 16'hb799;
   localparam logic [15:0] IDX_TIME    = 16'hb7b6;
   localparam logic [15:0] IDX_DATE    = 16'hb7b7;
   localparam logic [15:0] IDX_TMO     = 16'hb7c5;
   localparam logic [15:0] IDX_STATUS  = 16'hb7c6;
   localparam logic [15:0] IDX_HOST_T  = 16'hb7c7;
   localparam logic [15:0] IDX_HOST_D  = 16'hb7c8;
   localparam logic [15:0] IDX_FIFO_LO = 16'hb7c9;
   localparam logic [15:0] IDX_FIFO_HI = 16'hb7ca;
   // command word fields
   localparam logic [31:0] CMD_CLEAR      = 32'h0000_0001;
   localparam logic [31:0] MODE_MASK      = 32'h0000_0006;
   localparam logic [31:0] MODE_OFF       = 32'h0000_0000;
   localparam logic [31:0] MODE_STANDARD  = 32'h0000_0002;
   localparam logic [31:0] MODE_STARTCLR  = 32'h0000_0004;
   localparam logic [31:0] SRC_MASK       = 32'h0000_0700;
   localparam logic [31:0] SRC_SAMPLE     = 32'h0000_0100;
   localparam logic [31:0] SRC_REF_RISE   = 32'h0000_0200;
   localparam logic [31:0] SRC_REF_FALL   = 32'h0000_0400;
   localparam logic [31:0] XIO_AUX        = 32'h0000_1000;
   localparam logic [31:0] XIO_INC        = 32'h0000_2000;
   localparam logic [31:0] FEAT_FIRST_A   = 32'h0001_0000;
   localparam logic [31:0] CMD_WRITE_MASK = 32'h0001_3706;
   localparam logic [31:0] CAPS_VALUE     = 32'h0001_3707;
   localparam logic [31:0] TMO_RESET      = 32'h0000_03e8;
   // entry layout
   localparam int ENTRY_W  = 64;
   localparam int AUX_W    = 8;
   localparam int INC_W    = 10;
   localparam int LOW_W    = 32;
   // time base for the edge timeout
   localparam int CLK_MHZ     = 100;
   localparam int MS_NS       = 1000000;
   localparam int CLK_NS      = 1000 / CLK_MHZ;
   localparam int MS_CYCLES   = MS_NS / CLK_NS;
endpackage

/* tsc_fifo_if.sv */
// carrier between capture logic and the timestamp store
`timescale 1ns/1ps
interface tsc_fifo_if;
   logic        push;
   logic [63:0] push_data;
   logic        full;
   logic        pop;
   logic [63:0] head;
   logic        empty;
   modport writer (output push, push_data, pop, input full, head, empty);
   modport store  (input push, push_data, pop, output full, head, empty);
endinterface

/* tsc_stamp_fifo.sv */
// timestamp store: simple synchronous fifo
`timescale 1ns/1ps
module tsc_stamp_fifo #(
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic      clock,
   input  wire logic      sys_rst,
   // fifo port
   tsc_fifo_if.store      fp
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("tsc_stamp_fifo: DEPTH must be a power of two >= 2");
   end
   logic [63:0]  mem [DEPTH];
   logic [AW:0]  wr_ff;
   logic [AW:0]  rd_ff;
   wire          do_push = fp.push && !fp.full;
   wire          do_pop  = fp.pop && !fp.empty;
   assign fp.empty = (wr_ff == rd_ff);
   assign fp.full  = (wr_ff[AW] != rd_ff[AW]) &&
                     (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
   assign fp.head  = mem[rd_ff[AW-1:0]];
   always_ff @(posedge clock) begin
      if (do_push) begin
         mem[wr_ff[AW-1:0]] <= fp.push_data;
      end
   end
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         wr_ff <= wr_ff + (AW+1)'(do_push);
         rd_ff <= rd_ff + (AW+1)'(do_pop);
      end
   end
endmodule // tsc_stamp_fifo

/* tsc_top.sv */
// trigger timestamp capture with avalon-mm register slave
`timescale 1ns/1ps
module tsc_top
   import tsc_pkg::*;
#(
   parameter int CNT_W = 48,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        sys_rst,
   // avalon-mm slave
   input  wire logic [17:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // acquisition events, sample clock domain
   input  wire logic        sample_tick,
   input  wire logic        trigger,
   input  wire logic        card_start,
   input  wire logic        first_a_sample,
   input  wire logic        dual_time_base_mode,
   input  wire logic        clock_gen_active,
   // external pins
   input  wire logic        ref_clock_pin,
   input  wire logic [7:0]  aux_in_pin,
   input  wire logic [19:0] incr_count_pin,
   // status
   output logic             edge_timeout,
   output logic             overflow
);
   // incremental capture overlays the top bits of a count wider than 44
   if (CNT_W <= LOW_W || CNT_W > ENTRY_W - AUX_W) begin : g_bad_cnt_w
      $error("tsc_top: CNT_W out of range");
   end

   // pin synchronisers
   logic [1:0]  ref_sync_ff;
   logic [7:0]  aux_s1_ff;
   logic [7:0]  aux_s2_ff;
   logic [19:0] inc_s1_ff;
   logic [19:0] inc_s2_ff;
   logic        ref_prev_ff;
   always_ff @(posedge clock) begin
      ref_sync_ff <= {ref_sync_ff[0], ref_clock_pin};
      aux_s1_ff   <= aux_in_pin;
      aux_s2_ff   <= aux_s1_ff;
      inc_s1_ff   <= incr_count_pin;
      inc_s2_ff   <= inc_s1_ff;
      ref_prev_ff <= ref_sync_ff[1];
   end
   wire ref_rise = ref_sync_ff[1] && !ref_prev_ff;
   wire ref_fall = !ref_sync_ff[1] && ref_prev_ff;

   // registers
   logic [31:0] cmd_ff;
   logic [31:0] time_ff;
   logic [31:0] date_ff;
   logic [31:0] tmo_ff;
   logic [31:0] host_t_ff;
   logic [31:0] host_d_ff;
   logic        ovf_ff;
   logic        tmo_flag_ff;
   logic        rd_ack_ff;
   // status word bit positions
   localparam int ST_OVF = 0;
   localparam int ST_TMO = 1;

   wire [15:0] idx = avs_address[17:2];
   wire hit_cmd   = (idx == IDX_CMD);
   wire hit_caps  = (idx == IDX_CAPS);
   wire hit_time  = (idx == IDX_TIME);
   wire hit_date  = (idx == IDX_DATE);
   wire hit_tmo   = (idx == IDX_TMO);
   wire hit_stat  = (idx == IDX_STATUS);
   wire hit_ht    = (idx == IDX_HOST_T);
   wire hit_hd    = (idx == IDX_HOST_D);
   wire hit_flo   = (idx == IDX_FIFO_LO);
   wire hit_fhi   = (idx == IDX_FIFO_HI);

   wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                          {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   function automatic logic [31:0] merge(input logic [31:0] old_v);
      merge = (old_v & ~be_mask) | (avs_writedata & be_mask);
   endfunction

   // writes complete at once, reads take one wait cycle
   wire wr_cmd  = avs_write && hit_cmd;
   wire clear_req = wr_cmd && avs_byteenable[0] &&
                    ((avs_writedata & CMD_CLEAR) != 32'h0);
   wire clear_ok  = clear_req && clock_gen_active;
   assign avs_waitrequest = avs_read && !rd_ack_ff;

   wire [31:0] mode  = cmd_ff & MODE_MASK;
   wire        ts_on = (mode == MODE_STANDARD) || (mode == MODE_STARTCLR);
   wire        split = (cmd_ff & (SRC_REF_RISE | SRC_REF_FALL)) != 32'h0;
   wire ref_edge = ((cmd_ff & SRC_REF_RISE) != 32'h0) ? ref_rise :
                   ((cmd_ff & SRC_REF_FALL) != 32'h0) ? ref_fall :
                   1'b0;
   // clear on command, or on card start in start-clear mode
   wire cnt_clear = clear_ok ||
                    (card_start && mode == MODE_STARTCLR);

   // counter
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   localparam int HI_W = CNT_W - LOW_W;
   always_comb begin
      nxt_cnt = cnt_ff;
      if (cnt_clear) begin
         nxt_cnt = '0;
      end else if (split && ref_edge) begin
         nxt_cnt = {cnt_ff[CNT_W-1:LOW_W] + HI_W'(1), LOW_W'(0)};
      end else if (sample_tick) begin
         if (split) begin
            nxt_cnt = {cnt_ff[CNT_W-1:LOW_W],
                       cnt_ff[LOW_W-1:0] + LOW_W'(1)};
         end else begin
            nxt_cnt = cnt_ff + CNT_W'(1);
         end
      end
   end
   always_ff @(posedge clock) begin
      if (sys_rst) cnt_ff <= '0;
      else         cnt_ff <= nxt_cnt;
   end

   // edge wait timeout in split mode
   logic [31:0] ms_ff;
   logic [31:0] ms_cnt_ff;
   wire ms_tick = (ms_ff == 32'(MS_CYCLES - 1));
   always_ff @(posedge clock) begin
      if (sys_rst || !split || ref_edge || cnt_clear) begin
         ms_ff     <= '0;
         ms_cnt_ff <= '0;
      end else begin
         ms_ff     <= ms_tick ? 32'h0 : ms_ff + 32'h1;
         if (ms_tick && ms_cnt_ff != tmo_ff)
            ms_cnt_ff <= ms_cnt_ff + 32'h1;
      end
   end
   wire tmo_hit = split && (tmo_ff != 32'h0) && (ms_cnt_ff == tmo_ff);

   // entry build and capture
   tsc_fifo_if fif ();
   logic [ENTRY_W-1:0] entry;
   always_comb begin
      entry = ENTRY_W'(cnt_ff);
      if ((cmd_ff & XIO_INC) != 32'h0)
         entry[ENTRY_W-1 -: 2*INC_W] = inc_s2_ff;
      else if ((cmd_ff & XIO_AUX) != 32'h0)
         entry[ENTRY_W-1 -: AUX_W] = aux_s2_ff;
   end
   wire extra_a = ((cmd_ff & FEAT_FIRST_A) != 32'h0) &&
                  dual_time_base_mode && first_a_sample;
   wire want_push = ts_on && (trigger || extra_a);
   assign fif.push      = want_push;
   assign fif.push_data = entry;
   wire pop_lo = avs_read && hit_flo && rd_ack_ff;
   assign fif.pop = pop_lo;

   tsc_stamp_fifo #(.DEPTH(DEPTH)) u_store (
      .clock   (clock),
      .sys_rst (sys_rst),
      .fp      (fif)
   );

   // register writes
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cmd_ff      <= MODE_OFF;
         time_ff     <= '0;
         date_ff     <= '0;
         tmo_ff      <= TMO_RESET;
         host_t_ff   <= '0;
         host_d_ff   <= '0;
         ovf_ff      <= 1'b0;
         tmo_flag_ff <= 1'b0;
      end else begin
         if (wr_cmd)
            cmd_ff <= merge(cmd_ff) & CMD_WRITE_MASK;
         if (avs_write && hit_time) time_ff <= merge(time_ff);
         if (avs_write && hit_date) date_ff <= merge(date_ff);
         if (avs_write && hit_tmo)  tmo_ff  <= merge(tmo_ff);
         if (avs_write && hit_ht)   host_t_ff <= merge(host_t_ff);
         if (avs_write && hit_hd)   host_d_ff <= merge(host_d_ff);
         if (clear_ok) begin
            time_ff <= host_t_ff;
            date_ff <= host_d_ff;
         end
         // sticky flags: set beats a write-one clear
         if (want_push && fif.full)
            ovf_ff <= 1'b1;
         else if (avs_write && hit_stat && avs_writedata[ST_OVF])
            ovf_ff <= 1'b0;
         if (tmo_hit)
            tmo_flag_ff <= 1'b1;
         else if (avs_write && hit_stat && avs_writedata[ST_TMO])
            tmo_flag_ff <= 1'b0;
      end
   end

   // read path
   wire [31:0] status_w = {29'h0, fif.empty, tmo_flag_ff, ovf_ff};
   wire [31:0] rd_mux =
      hit_cmd  ? cmd_ff :
      hit_caps ? CAPS_VALUE :
      hit_time ? time_ff :
      hit_date ? date_ff :
      hit_tmo  ? tmo_ff :
      hit_stat ? status_w :
      hit_ht   ? host_t_ff :
      hit_hd   ? host_d_ff :
      hit_fhi  ? fif.head[63:32] :
      hit_flo  ? fif.head[31:0] :
      32'h0;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rd_ack_ff    <= 1'b0;
         avs_readdata <= '0;
      end else begin
         rd_ack_ff <= avs_read && !rd_ack_ff;
         if (avs_read && !rd_ack_ff)
            avs_readdata <= rd_mux;
      end
   end

   assign overflow     = ovf_ff;
   assign edge_timeout = tmo_flag_ff;

   chk_clear_zeroes: assert property (
      @(posedge clock) disable iff (sys_rst)
      clear_ok |=> (cnt_ff == '0))
      else $error("counter not zero after clear");
   chk_clear_gated: assert property (
      @(posedge clock) disable iff (sys_rst)
      (clear_req && !clock_gen_active && !card_start && !sample_tick
       && !ref_edge) |=> (cnt_ff == $past(cnt_ff)))
      else $error("clear acted without clock generation");
   chk_full_count: assert property (
      @(posedge clock) disable iff (sys_rst)
      (!split && sample_tick && !cnt_clear) |=>
      (cnt_ff == $past(cnt_ff) + CNT_W'(1)))
      else $error("full counter did not step");
   chk_split_edge: assert property (
      @(posedge clock) disable iff (sys_rst)
      (split && ref_edge && !cnt_clear) |=>
      (cnt_ff[LOW_W-1:0] == '0 &&
       cnt_ff[CNT_W-1:LOW_W] == $past(cnt_ff[CNT_W-1:LOW_W]) + HI_W'(1)))
      else $error("split edge wrong");
   chk_start_clear: assert property (
      @(posedge clock) disable iff (sys_rst)
      (card_start && mode == MODE_STARTCLR) |=> (cnt_ff == '0))
      else $error("start did not clear");
   chk_off_nopush: assert property (
      @(posedge clock) disable iff (sys_rst)
      ((cmd_ff & MODE_MASK) == MODE_OFF) |-> !fif.push)
      else $error("push while disabled");
   chk_ovf_set: assert property (
      @(posedge clock) disable iff (sys_rst)
      (want_push && fif.full) |=> ovf_ff ##1
      (ovf_ff || $past(avs_write && hit_stat && avs_writedata[ST_OVF])))
      else $error("overflow not raised");
   chk_upper_zero: assert property (
      @(posedge clock) disable iff (sys_rst)
      ((cmd_ff & (XIO_AUX | XIO_INC)) == 32'h0) |->
      (entry[ENTRY_W-1:CNT_W] == '0))
      else $error("upper bits not zero");
   chk_one_stamp: assert property (
      @(posedge clock) disable iff (sys_rst)
      ((cmd_ff & FEAT_FIRST_A) == 32'h0 && !trigger) |-> !fif.push)
      else $error("stamp without trigger");
   // counter stepping and holding
   chk_split_tick: assert property (
      @(posedge clock) disable iff (sys_rst)
      (split && sample_tick && !ref_edge && !cnt_clear) |=>
      (cnt_ff[LOW_W-1:0] == $past(cnt_ff[LOW_W-1:0]) + LOW_W'(1) &&
       cnt_ff[CNT_W-1:LOW_W] == $past(cnt_ff[CNT_W-1:LOW_W])))
      else $error("split low part did not step");
   chk_count_hold: assert property (
      @(posedge clock) disable iff (sys_rst)
      (!sample_tick && !cnt_clear && !(split && ref_edge)) |=>
      (cnt_ff == $past(cnt_ff)))
      else $error("counter moved without a sample");
   chk_std_start: assert property (
      @(posedge clock) disable iff (sys_rst)
      (card_start && (cmd_ff & MODE_MASK) == MODE_STANDARD && !clear_ok
       && !sample_tick && !(split && ref_edge)) |=>
      (cnt_ff == $past(cnt_ff)))
      else $error("card start moved the free running count");
   // capture contents
   chk_trig_push: assert property (
      @(posedge clock) disable iff (sys_rst)
      (trigger && ((cmd_ff & MODE_MASK) == MODE_STANDARD ||
                   (cmd_ff & MODE_MASK) == MODE_STARTCLR)) |-> fif.push)
      else $error("trigger not stored");
   chk_first_a: assert property (
      @(posedge clock) disable iff (sys_rst)
      ((cmd_ff & (FEAT_FIRST_A | MODE_MASK)) ==
       (FEAT_FIRST_A | MODE_STANDARD) && dual_time_base_mode &&
       first_a_sample) |-> fif.push)
      else $error("first A area stamp missing");
   chk_aux_byte: assert property (
      @(posedge clock) disable iff (sys_rst)
      (fif.push && (cmd_ff & (XIO_AUX | XIO_INC)) == XIO_AUX) |->
      (fif.push_data[ENTRY_W-1 -: AUX_W] == aux_s2_ff &&
       fif.push_data[LOW_W-1:0] == cnt_ff[LOW_W-1:0]))
      else $error("auxiliary byte misplaced");
   chk_inc_bits: assert property (
      @(posedge clock) disable iff (sys_rst)
      (fif.push && (cmd_ff & XIO_INC) != 32'h0) |->
      (fif.push_data[ENTRY_W-1 -: 2*INC_W] == inc_s2_ff &&
       fif.push_data[LOW_W-1:0] == cnt_ff[LOW_W-1:0]))
      else $error("incremental counts misplaced");
   // latched host clock, capability bitmap and sticky flags
   chk_time_latch: assert property (
      @(posedge clock) disable iff (sys_rst)
      clear_ok |=> (time_ff == $past(host_t_ff)))
      else $error("reset time not latched");
   chk_date_latch: assert property (
      @(posedge clock) disable iff (sys_rst)
      clear_ok |=> (date_ff == $past(host_d_ff)))
      else $error("reset date not latched");
   chk_caps_read: assert property (
      @(posedge clock) disable iff (sys_rst)
      (avs_read && hit_caps && !rd_ack_ff) |=> (avs_readdata == CAPS_VALUE))
      else $error("capability bitmap wrong");
   chk_tmo_flag: assert property (
      @(posedge clock) disable iff (sys_rst)
      tmo_hit |=> tmo_flag_ff)
      else $error("edge timeout not flagged");
   chk_tmo_hold: assert property (
      @(posedge clock) disable iff (sys_rst)
      (tmo_flag_ff && !(avs_write && hit_stat && avs_writedata[ST_TMO]))
      |=> tmo_flag_ff)
      else $error("edge timeout flag lost");
   chk_ovf_hold: assert property (
      @(posedge clock) disable iff (sys_rst)
      (ovf_ff && !(avs_write && hit_stat && avs_writedata[ST_OVF]))
      |=> ovf_ff)
      else $error("overflow flag lost");
   chk_ovf_drop: assert property (
      @(posedge clock) disable iff (sys_rst)
      (fif.push && fif.full && !fif.pop) |=> fif.full)
      else $error("store not full after a dropped entry");
endmodule // tsc_top

/* tsc_far_model.sv */
// far side model: reference clock and captured input pins
`timescale 1ns/1ps
module tsc_far_model (
   // clock
   input  wire logic  clock,
   // pins toward the block
   output logic        ref_clock_pin,
   output logic [7:0]  aux_in_pin,
   output logic [19:0] incr_count_pin
);
   initial begin
      ref_clock_pin = 1'b0;
      aux_in_pin = 8'h00;
      incr_count_pin = 20'h00000;
   end
   // new level, then settle past synchroniser and edge detect
   task automatic ref_set(input logic lvl);
      @(posedge clock);
      ref_clock_pin <= lvl;
      repeat (6) @(posedge clock);
   endtask
   task automatic pins_set(input logic [7:0] a, input logic [19:0] n);
      @(posedge clock);
      aux_in_pin <= a;
      incr_count_pin <= n;
      repeat (3) @(posedge clock);
   endtask
endmodule // tsc_far_model

/* trigger_timestamp_capture_tb.sv */
// self-checking bench for the trigger timestamp capture block
`timescale 1ns/1ps
module trigger_timestamp_capture_tb;
   import tsc_pkg::*;
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   logic [17:0] avs_address = 18'h00000;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        sample_tick = 1'b0;
   logic        trigger = 1'b0;
   logic        card_start = 1'b0;
   logic        first_a_sample = 1'b0;
   logic        dual_time_base_mode = 1'b0;
   logic        clock_gen_active = 1'b1;
   logic        ref_clock_pin;
   logic [7:0]  aux_in_pin;
   logic [19:0] incr_count_pin;
   logic        edge_timeout;
   logic        overflow;
   logic [31:0] rd;
   logic [31:0] cmd;
   int          i;
   int          err_total = 0;
   int          n_compared = 0;

   always #5 clock = ~clock;

   tsc_top u_dut (
      .clock(clock), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .sample_tick(sample_tick),
      .trigger(trigger), .card_start(card_start),
      .first_a_sample(first_a_sample),
      .dual_time_base_mode(dual_time_base_mode),
      .clock_gen_active(clock_gen_active),
      .ref_clock_pin(ref_clock_pin), .aux_in_pin(aux_in_pin),
      .incr_count_pin(incr_count_pin), .edge_timeout(edge_timeout),
      .overflow(overflow)
   );
   tsc_far_model u_far (
      .clock(clock), .ref_clock_pin(ref_clock_pin),
      .aux_in_pin(aux_in_pin), .incr_count_pin(incr_count_pin)
   );

   task automatic close_out();
      if (err_total == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [15:0] idx,
                      input logic [31:0] wd);
      int n;
      @(posedge clock);
      avs_address <= {idx, 2'b00};
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= ~wr;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         err_total++;
         close_out();
      end
   endtask
   task automatic wr(input logic [15:0] idx, input logic [31:0] d);
      bus(1'b1, idx, d);
   endtask
   task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0);
      chk32(rd, exp);
   endtask
   task automatic popchk(input logic [31:0] hi, input logic [31:0] lo);
      rdchk(IDX_FIFO_HI, hi);
      rdchk(IDX_FIFO_LO, lo);
   endtask
   // sample_tick high for exactly k edges
   task automatic tick(input int k);
      @(posedge clock);
      sample_tick <= 1'b1;
      repeat (k) @(posedge clock);
      sample_tick <= 1'b0;
   endtask
   // 0 trigger, 1 card start, 2 first A sample
   task automatic pulse(input int w);
      @(posedge clock);
      if (w == 0) trigger <= 1'b1;
      else if (w == 1) card_start <= 1'b1;
      else first_a_sample <= 1'b1;
      @(posedge clock);
      {trigger, card_start, first_a_sample} <= 3'b000;
   endtask

   initial begin
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      rdchk(IDX_CAPS, CAPS_VALUE);
      wr(IDX_CAPS, 32'h0);
      rdchk(IDX_CAPS, CAPS_VALUE);
      rdchk(IDX_TMO, TMO_RESET);
      wr(IDX_TMO, 32'h0000_0005);
      rdchk(IDX_TMO, 32'h0000_0005);
      wr(16'h0001, 32'hffff_ffff);
      rdchk(16'h0001, 32'h0);
      // host clock copied at clear
      wr(IDX_HOST_T, 32'h000c_223b);
      wr(IDX_HOST_D, 32'h07e4_0507);
      cmd = MODE_STANDARD | SRC_SAMPLE | XIO_AUX;
      wr(IDX_CMD, cmd);
      rdchk(IDX_CMD, cmd);
      cmd = MODE_STANDARD | SRC_SAMPLE;
      wr(IDX_CMD, cmd);
      wr(IDX_CMD, cmd | CMD_CLEAR);
      rdchk(IDX_TIME, 32'h000c_223b);
      rdchk(IDX_DATE, 32'h07e4_0507);
      tick(7);
      pulse(0);
      rdchk(IDX_STATUS, 32'h0);
      popchk(32'h0, 32'h7);
      rdchk(IDX_STATUS, 32'h4);
      pulse(1);
      tick(3);
      pulse(0);
      popchk(32'h0, 32'ha);
      // clear refused while clock generation idles
      @(posedge clock);
      clock_gen_active <= 1'b0;
      wr(IDX_CMD, cmd | CMD_CLEAR);
      pulse(0);
      popchk(32'h0, 32'ha);
      @(posedge clock);
      clock_gen_active <= 1'b1;
      wr(IDX_CMD, MODE_STARTCLR | SRC_SAMPLE);
      tick(4);
      pulse(1);
      tick(2);
      pulse(0);
      popchk(32'h0, 32'h2);
      u_far.pins_set(8'ha5, 20'h5a3c1);
      for (i = 0; i < 2; i++) begin
         cmd = MODE_STANDARD | SRC_SAMPLE | (i ? XIO_INC : XIO_AUX);
         wr(IDX_CMD, cmd | CMD_CLEAR);
         tick(1);
         pulse(0);
         popchk(i ? 32'h5a3c_1000 : 32'ha500_0000, 32'h1);
      end
      for (i = 0; i < 2; i++) begin
         cmd = MODE_STANDARD | (i ? SRC_REF_FALL : SRC_REF_RISE);
         wr(IDX_CMD, cmd);
         wr(IDX_CMD, cmd | CMD_CLEAR);
         u_far.ref_set(1'b1);
         tick(2);
         pulse(0);
         u_far.ref_set(1'b0);
         tick(3);
         pulse(0);
         popchk(i ? 32'h0 : 32'h1, 32'h2);
         popchk(32'h1, i ? 32'h3 : 32'h5);
      end
      wr(IDX_CMD, MODE_OFF | SRC_SAMPLE);
      pulse(0);
      rdchk(IDX_STATUS, 32'h4);
      @(posedge clock);
      dual_time_base_mode <= 1'b1;
      wr(IDX_CMD, MODE_STANDARD | SRC_SAMPLE | FEAT_FIRST_A);
      pulse(2);
      rdchk(IDX_STATUS, 32'h0);
      popchk(32'h1, 32'h3);
      rdchk(IDX_STATUS, 32'h4);
      wr(IDX_CMD, MODE_STANDARD | SRC_SAMPLE);
      pulse(2);
      rdchk(IDX_STATUS, 32'h4);
      // one trigger more than the store holds
      @(posedge clock);
      trigger <= 1'b1;
      repeat (17) @(posedge clock);
      trigger <= 1'b0;
      rdchk(IDX_STATUS, 32'h1);
      chk32({31'h0, overflow}, 32'h1);
      wr(IDX_STATUS, 32'h1);
      rdchk(IDX_STATUS, 32'h0);
      repeat (16) begin
         popchk(32'h1, 32'h3);
      end
      rdchk(IDX_STATUS, 32'h4);
      chk32({31'h0, edge_timeout}, 32'h0);
      close_out();
   end
endmodule // trigger_timestamp_capture_tb
